// *** hdl/itc_core.sv ***
// Interval timer compare core with input noise filters and register port.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module itc_core
    import itc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [3:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RDATA,
    input wire logic CAPTURE_TRIGGER_IN0,
    input wire logic CAPTURE_TRIGGER_IN1,
    output logic TIMER_OUT0,
    output logic TIMER_OUT1,
    output logic CYCLE_MATCH_IRQ,
    output logic SECOND_MATCH_IRQ,
    output logic TRIG_EDGE0,
    output logic TRIG_EDGE1
);
    typedef enum logic [1:0] {
        ITC_ST_IDLE = 2'b00,
        ITC_ST_START = 2'b01,
        ITC_ST_RUN = 2'b11
    } itc_state_t;

    itc_bus_t bus;
    assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

    logic [7:0] timer_control0_reg;
    logic [7:0] timer_control1_reg;
    logic [7:0] input_edge_control_reg;
    logic [7:0] input_filter_control_reg;
    logic [15:0] cycle_compare_reg;
    logic [15:0] second_compare_reg;
    logic [15:0] cycle_buffer_reg;
    logic [15:0] second_buffer_reg;
    logic [15:0] count_reg;
    logic batch_arm_reg;
    itc_state_t state_reg;
    logic [15:0] rdata_reg;
    logic out0_reg, out1_reg;
    itc_irq_t irq_reg;
    logic [6:0] presc_reg;
    logic [1:0] fdiv_reg;
    logic [1:0] edge_reg;

    wire wr_ctl0 = bus.wr && bus.addr == ITC_ADDR_CTL0;
    wire wr_ctl1 = bus.wr && bus.addr == ITC_ADDR_CTL1;
    wire wr_ioc1 = bus.wr && bus.addr == ITC_ADDR_IOC1;
    wire wr_cycle_buffer = bus.wr && bus.addr == ITC_ADDR_CYCLE_BUFFER;
    wire wr_second_buffer = bus.wr && bus.addr == ITC_ADDR_SECOND_BUFFER;
    wire wr_nfc = bus.wr && bus.addr == ITC_ADDR_NFC;
    wire count_enable_bit = timer_control0_reg[ITC_CTL0_CE_BIT];
    wire [2:0] clk_sel = timer_control0_reg[ITC_CTL0_CKS_LSB +: 3];
    wire [2:0] operating_mode_field = timer_control1_reg[ITC_CTL1_MD_LSB +: 3];
    wire software_trigger_bit = timer_control1_reg[ITC_CTL1_EST_BIT];
    wire external_count_clock_select = timer_control1_reg[ITC_CTL1_EEE_BIT];
    wire input_filter_enable = input_filter_control_reg[ITC_NFC_EN_BIT];
    wire filter_sample_clock_select = input_filter_control_reg[ITC_NFC_SEL_BIT];

    // [R04] batch mode decode
    function automatic logic itc_is_batch(input logic [2:0] md);
        itc_is_batch = (md == ITC_MD_EXTTRIG) || (md == ITC_MD_PWM);
    endfunction
    // [R04] immediate mode decode
    function automatic logic itc_is_immediate(input logic [2:0] md);
        itc_is_immediate = (md == ITC_MD_INTERVAL) || (md == ITC_MD_EVENT) ||
                           (md == ITC_MD_ONESHOT) || (md == ITC_MD_FREERUN);
    endfunction

    // [R01] filter sample clock select
    wire sample_tick = filter_sample_clock_select ? (fdiv_reg == ITC_DIV4_LAST) : 1'b1;

    // [R02] three-sample noise filter
    logic [1:0] filt_level;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_filt
            logic sync1_reg, sync2_reg, level_reg;
            logic [1:0] run_reg;
            wire raw_in = (gi == 0) ? CAPTURE_TRIGGER_IN0 : CAPTURE_TRIGGER_IN1;
            wire differs = sync2_reg != level_reg;
            wire accept = sample_tick && differs && (run_reg == 2'(ITC_FILT_SAMPLES - 1));
            always_ff @(posedge CLK or negedge RST_N) begin
                if (!RST_N) begin
                    sync1_reg <= 1'b0;
                    sync2_reg <= 1'b0;
                    level_reg <= 1'b0;
                    run_reg <= 2'h0;
                end else begin
                    sync1_reg <= raw_in;
                    sync2_reg <= sync1_reg;
                    if (!input_filter_enable) begin
                        level_reg <= sync2_reg;
                        run_reg <= 2'h0;
                    end else if (sample_tick) begin
                        if (!differs)
                            run_reg <= 2'h0;
                        else if (accept) begin
                            level_reg <= sync2_reg;
                            run_reg <= 2'h0;
                        end else
                            run_reg <= run_reg + 2'h1;
                    end
                end
            end
            assign filt_level[gi] = level_reg;
        end
    endgenerate

    // [R23] edge detect on filtered level
    logic [1:0] filt_prev_reg;
    wire [1:0] filt_edge = filt_level ^ filt_prev_reg;

    // [R03] triggers only in trigger modes
    wire trig_mode = operating_mode_field == ITC_MD_EXTTRIG || operating_mode_field == ITC_MD_ONESHOT;
    wire [1:0] trig_next = trig_mode ? {filt_edge[1], filt_edge[0] | software_trigger_bit} : 2'b00;

    // Count clock: prescaled peripheral clock, or filtered edges of input 0.
    wire presc_tick = (clk_sel == ITC_PRESC_RST) ? 1'b1 : (presc_reg[clk_sel - 3'h1 +: 1] == 1'b1 &&
                      presc_reg[6:0] == 7'((1 << clk_sel) - 1));
    wire count_tick = external_count_clock_select ? filt_edge[0] : presc_tick;

    // [R10] only cycle buffer match clears
    wire match0 = count_reg == cycle_buffer_reg;
    wire match1 = count_reg == second_buffer_reg;
    // Stopping acts at once, so a tick in the stop cycle can neither match nor start.
    wire running = count_enable_bit && state_reg == ITC_ST_RUN;
    wire start_tick = count_enable_bit && state_reg == ITC_ST_START && count_tick;
    // [R13] cycle match event
    // [R15] zero compare matches every tick
    wire cyc_event = running && count_tick && match0;
    // [R19] second match event
    wire sec_event = running && count_tick && match1;
    // [R16] wrap at FFFF raises nothing
    wire [15:0] count_next = !count_enable_bit ? ITC_CNT_IDLE :
                             start_tick || cyc_event ? ITC_CNT_ZERO :
                             running && count_tick ? count_reg + 16'h0001 : count_reg;

    wire imm_mode = itc_is_immediate(operating_mode_field);
    wire batch_mode = itc_is_batch(operating_mode_field);
    // [R08] armed batch transfer on cycle match
    wire batch_xfer = batch_mode && cyc_event && batch_arm_reg;

    wire [15:0] rdata_next = bus.addr == ITC_ADDR_CTL0 ? {8'h00, timer_control0_reg} :
                             bus.addr == ITC_ADDR_CTL1 ? {8'h00, timer_control1_reg} :
                             bus.addr == ITC_ADDR_IOC1 ? {8'h00, input_edge_control_reg} :
                             bus.addr == ITC_ADDR_OPT0 ? 16'h0000 :
                             bus.addr == ITC_ADDR_CYCLE_BUFFER ? cycle_compare_reg :
                             bus.addr == ITC_ADDR_SECOND_BUFFER ? second_compare_reg :
                             bus.addr == ITC_ADDR_CNT ? (count_enable_bit ? count_reg : ITC_CNT_ZERO) :
                             bus.addr == ITC_ADDR_NFC ? {8'h00, input_filter_control_reg} :
                             bus.addr == ITC_ADDR_STAT ? {13'h0000, batch_arm_reg, out1_reg, out0_reg} :
                             16'h0000;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            timer_control0_reg <= ITC_REG8_RST;
            timer_control1_reg <= ITC_REG8_RST;
            input_edge_control_reg <= ITC_REG8_RST;
            input_filter_control_reg <= ITC_REG8_RST;
        end else begin
            if (wr_ctl0)
                timer_control0_reg <= bus.wdata[7:0];
            // The software trigger bit reads back as zero; it acts once.
            if (wr_ctl1)
                timer_control1_reg <= bus.wdata[7:0];
            else
                timer_control1_reg[ITC_CTL1_EST_BIT] <= 1'b0;
            if (wr_ioc1)
                input_edge_control_reg <= bus.wdata[7:0];
            if (wr_nfc)
                input_filter_control_reg <= bus.wdata[7:0] & 8'h81;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cycle_compare_reg <= ITC_CCR_RST;
            second_compare_reg <= ITC_CCR_RST;
        end else begin
            if (wr_cycle_buffer)
                cycle_compare_reg <= bus.wdata;
            if (wr_second_buffer)
                second_compare_reg <= bus.wdata;
        end
    end

    // Arm set by a second-compare write wins over the clear by a transfer.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            batch_arm_reg <= 1'b0;
        else if (wr_second_buffer && count_enable_bit)
            batch_arm_reg <= 1'b1;
        else if (batch_xfer || !count_enable_bit)
            batch_arm_reg <= 1'b0;
    end

    // [R07] immediate copy, [R12] load at start
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cycle_buffer_reg <= ITC_CCR_RST;
            second_buffer_reg <= ITC_CCR_RST;
        end else if (state_reg != ITC_ST_RUN || batch_xfer || (imm_mode && !batch_mode)) begin
            cycle_buffer_reg <= cycle_compare_reg;
            second_buffer_reg <= second_compare_reg;
        end
    end

    // [R11] count enable runs the machine; [R12] start on first count tick
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N)
            state_reg <= ITC_ST_IDLE;
        else if (!count_enable_bit)
            state_reg <= ITC_ST_IDLE;
        else
            unique case (state_reg)
                ITC_ST_IDLE: state_reg <= ITC_ST_START;
                ITC_ST_START: state_reg <= count_tick ? ITC_ST_RUN : ITC_ST_START;
                ITC_ST_RUN: state_reg <= ITC_ST_RUN;
                default: state_reg <= ITC_ST_IDLE;
            endcase
    end

    // [R18] free count wraps through FFFF to the new match
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            count_reg <= ITC_CNT_IDLE;
            presc_reg <= 7'h00;
            fdiv_reg <= 2'h0;
            filt_prev_reg <= 2'b00;
        end else begin
            count_reg <= count_next;
            presc_reg <= (!count_enable_bit || presc_tick) ? 7'h00 : presc_reg + 7'h01;
            fdiv_reg <= fdiv_reg + 2'h1;
            filt_prev_reg <= filt_level;
        end
    end

    // [R13] toggle out0 on start and cycle match
    // [R22] one-cycle irq pulses
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            out0_reg <= 1'b0;
            out1_reg <= 1'b0;
            irq_reg <= '0;
            edge_reg <= 2'b00;
            rdata_reg <= 16'h0000;
        end else begin
            if (start_tick || cyc_event)
                out0_reg <= ~out0_reg;
            // [R20] no second match, no toggle
            if (sec_event)
                out1_reg <= ~out1_reg;
            irq_reg.cc0 <= cyc_event;
            irq_reg.cc1 <= sec_event;
            edge_reg <= trig_next;
            rdata_reg <= bus.rd ? rdata_next : 16'h0000;
        end
    end

    assign RDATA = rdata_reg;
    assign TIMER_OUT0 = out0_reg;
    assign TIMER_OUT1 = out1_reg;
    assign CYCLE_MATCH_IRQ = irq_reg.cc0;
    assign SECOND_MATCH_IRQ = irq_reg.cc1;
    assign TRIG_EDGE0 = edge_reg[0];
    assign TRIG_EDGE1 = edge_reg[1];

    // [R14] compare plus one count ticks between cycle irqs
    // A compare rewritten mid-cycle may be overtaken and wrap, so that cycle is not measured.
    logic [16:0] gap_reg;
    logic gap_ok_reg;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            gap_reg <= 17'h00000;
            gap_ok_reg <= 1'b0;
        end else begin
            if (cyc_event || !running)
                gap_reg <= 17'h00000;
            else if (count_tick)
                gap_reg <= gap_reg + 17'h00001;
            if (wr_cycle_buffer)
                gap_ok_reg <= 1'b0;
            else if (cyc_event || !running)
                gap_ok_reg <= 1'b1;
        end
    end

    AST_CLEAR_ON_CYCLE: assert property (@(posedge CLK) disable iff (!RST_N) // [R13]
        cyc_event |=> count_reg == ITC_CNT_ZERO && CYCLE_MATCH_IRQ && $changed(TIMER_OUT0))
        else $error("cycle match did not clear, toggle and interrupt");
    AST_SECOND_NO_CLEAR: assert property (@(posedge CLK) disable iff (!RST_N) // [R10]
        sec_event && !cyc_event |=> count_reg != ITC_CNT_ZERO || $past(count_reg) == ITC_CNT_IDLE)
        else $error("second match cleared the counter");
    AST_IRQ_PULSE: assert property (@(posedge CLK) disable iff (!RST_N) // [R22]
        CYCLE_MATCH_IRQ && $past(cycle_buffer_reg) != ITC_CNT_ZERO |=> !CYCLE_MATCH_IRQ)
        else $error("cycle interrupt longer than one cycle");
    AST_OUT1_QUIET: assert property (@(posedge CLK) disable iff (!RST_N) // [R20]
        !sec_event |=> $stable(TIMER_OUT1))
        else $error("second output moved without a match");
    AST_START_WRAP: assert property (@(posedge CLK) disable iff (!RST_N) // [R12]
        start_tick |=> count_reg == ITC_CNT_ZERO && $changed(TIMER_OUT0) && state_reg == ITC_ST_RUN)
        else $error("start did not wrap counter and toggle output");
    AST_IMMEDIATE_COPY: assert property (@(posedge CLK) disable iff (!RST_N) // [R07]
        wr_cycle_buffer && imm_mode && running && $stable(timer_control1_reg) ##1 running |=>
        cycle_buffer_reg == $past(cycle_compare_reg))
        else $error("immediate write did not reach the buffer");
    AST_BATCH_HOLD: assert property (@(posedge CLK) disable iff (!RST_N) // [R08]
        running && batch_mode && !batch_xfer |=> $stable(cycle_buffer_reg))
        else $error("batch buffer changed without an armed match");
    AST_TRIG_IGNORED: assert property (@(posedge CLK) disable iff (!RST_N) // [R03]
        !trig_mode |=> !TRIG_EDGE0 && !TRIG_EDGE1)
        else $error("trigger passed outside trigger modes");
    AST_FILTER_HOLD: assert property (@(posedge CLK) disable iff (!RST_N) // [R02]
        input_filter_enable && $past(input_filter_enable) && $changed(filt_level[0]) |->
        $past(g_filt[0].run_reg) == 2'h2)
        else $error("filter accepted level before three samples");
    AST_INTERVAL: assert property (@(posedge CLK) disable iff (!RST_N) // [R14]
        cyc_event && imm_mode && gap_ok_reg |-> gap_reg <= {1'b0, cycle_buffer_reg})
        else $error("interval longer than compare plus one");
    // With the filter off a one-clock pulse rightly gives two edges in a row.
    AST_EDGE_ONCE: assert property (@(posedge CLK) disable iff (!RST_N) // [R23]
        input_filter_enable && filt_edge[0] |=> !filt_edge[0])
        else $error("one level change gave two edges");
    AST_ZERO_HOLD: assert property (@(posedge CLK) disable iff (!RST_N) // [R15]
        cyc_event && cycle_buffer_reg == ITC_CNT_ZERO |=> count_reg == ITC_CNT_ZERO && CYCLE_MATCH_IRQ)
        else $error("zero compare let the counter move");
    AST_STOP_QUIET: assert property (@(posedge CLK) disable iff (!RST_N) // [R11]
        !count_enable_bit |=> !CYCLE_MATCH_IRQ && !SECOND_MATCH_IRQ && count_reg == ITC_CNT_IDLE)
        else $error("stopped counter moved or interrupted");
    AST_BATCH_COPY: assert property (@(posedge CLK) disable iff (!RST_N) // [R08]
        batch_xfer && !wr_second_buffer |=> !batch_arm_reg && cycle_buffer_reg == $past(cycle_compare_reg) &&
        second_buffer_reg == $past(second_compare_reg))
        else $error("armed batch transfer did not copy both compares");
    COV_START: cover property (@(posedge CLK) disable iff (!RST_N) start_tick);
    COV_CYCLE: cover property (@(posedge CLK) disable iff (!RST_N) cyc_event);
    COV_SECOND: cover property (@(posedge CLK) disable iff (!RST_N) sec_event && !cyc_event);
    COV_BATCH: cover property (@(posedge CLK) disable iff (!RST_N) batch_xfer);
    COV_ZERO: cover property (@(posedge CLK) disable iff (!RST_N) cyc_event && cycle_buffer_reg == ITC_CNT_ZERO);
endmodule
`default_nettype wire

// *** hdl/itc_pkg.sv ***
// Constants, register map and types for the interval timer compare core.
//
// Contract
// [R01] Filter enable; sample clock fxx or fxx/4
// [R02] Three equal samples accept level; shorter rejected
// [R03] Triggers only in trigger and one-shot modes
// [R04] Batch transfer modes versus immediate transfer modes
// [R05] Event count mode needs edge select 00
// [R06] Trigger/one-shot/width modes need internal clock
// [R07] Immediate modes copy compare writes at once
// [R08] Batch copies both on cycle match if armed
// [R09] Software writes first then second compare
// [R10] Only cycle buffer match clears counter
// [R11] Mode 000 is interval, count enable runs
// [R12] Start: FFFF to 0000, toggle out0, load
// [R13] Cycle match clears, toggles out0, raises irq
// [R14] Interval is compare plus one counts
// [R15] Compare zero: irq every count after first
// [R16] Compare FFFF: no overflow irq or flag
// [R17] Stop counter before lowering cycle compare
// [R18] Lowered compare: wrap through FFFF, then match
// [R19] Second compare not above first toggles out1
// [R20] Second compare above first: no irq, no toggle
// [R21] Wait three sample clocks after clock change
// [R22] Match irqs are one-cycle pulses
// [R23] Filter output edges detected synchronously, once each
package itc_pkg;
    localparam logic [3:0] ITC_ADDR_CTL0 = 4'h0;
    localparam logic [3:0] ITC_ADDR_CTL1 = 4'h1;
    localparam logic [3:0] ITC_ADDR_IOC1 = 4'h2;
    localparam logic [3:0] ITC_ADDR_OPT0 = 4'h3;
    localparam logic [3:0] ITC_ADDR_CYCLE_BUFFER = 4'h4;
    localparam logic [3:0] ITC_ADDR_SECOND_BUFFER = 4'h5;
    localparam logic [3:0] ITC_ADDR_CNT = 4'h6;
    localparam logic [3:0] ITC_ADDR_NFC = 4'h7;
    localparam logic [3:0] ITC_ADDR_STAT = 4'h8;
    localparam int ITC_CTL0_CE_BIT = 7;
    localparam int ITC_CTL0_CKS_LSB = 0;
    localparam int ITC_CTL1_EST_BIT = 6;
    localparam int ITC_CTL1_EEE_BIT = 5;
    localparam int ITC_CTL1_MD_LSB = 0;
    localparam int ITC_IOC1_IS_LSB = 0;
    localparam int ITC_OPT0_OVF_BIT = 0;
    localparam int ITC_NFC_EN_BIT = 7;
    localparam int ITC_NFC_SEL_BIT = 0;
    localparam logic [15:0] ITC_CCR_RST = 16'h0000;
    localparam logic [15:0] ITC_CNT_IDLE = 16'hffff;
    localparam logic [15:0] ITC_CNT_ZERO = 16'h0000;
    localparam logic [7:0] ITC_REG8_RST = 8'h00;
    localparam int ITC_FILT_SAMPLES = 3;
    localparam logic [1:0] ITC_DIV4_LAST = 2'h3;
    localparam logic [2:0] ITC_PRESC_RST = 3'h0;
    typedef enum logic [2:0] {
        ITC_MD_INTERVAL = 3'h0,
        ITC_MD_EVENT = 3'h1,
        ITC_MD_EXTTRIG = 3'h2,
        ITC_MD_ONESHOT = 3'h3,
        ITC_MD_PWM = 3'h4,
        ITC_MD_FREERUN = 3'h5,
        ITC_MD_PULSEW = 3'h6
    } itc_mode_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } itc_bus_t;
    typedef struct packed {
        logic cc0;
        logic cc1;
    } itc_irq_t;
endpackage

// *** verif/interval_timer_compare_core_bench.sv ***
// Self-checking bench for the interval timer compare core.
`timescale 1ns/1ps
`default_nettype none
module interval_timer_compare_core_bench
    import itc_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic in0, in1, out0, out1, irq0, irq1, edge0, edge1, t, t1;
    logic [15:0] v;
    int bad_count = 0;
    int compares = 0;
    int e0 = 0;
    int e1 = 0;
    int s1 = 0;
    int a, a1, n;

    itc_core dut (.CLK(clk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .CAPTURE_TRIGGER_IN0(in0), .CAPTURE_TRIGGER_IN1(in1), .TIMER_OUT0(out0), .TIMER_OUT1(out1),
        .CYCLE_MATCH_IRQ(irq0), .SECOND_MATCH_IRQ(irq1), .TRIG_EDGE0(edge0), .TRIG_EDGE1(edge1));
    itc_pin_src src (.CLK(clk), .PIN0(in0), .PIN1(in1));

    initial begin
        forever #12.5 clk = ~clk;
    end

    // Counting on the rising edge keeps the tallies clear of the checks made at the falling edge.
    always @(posedge clk) begin
        e0 += (edge0 === 1'b1);
        e1 += (edge1 === 1'b1);
        s1 += (irq1 === 1'b1);
    end

    task automatic conclude();
        if (bad_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic chkb(input logic b, input logic e);
        chk({15'h0000, b}, {15'h0000, e});
    endtask

    task automatic wreg(input logic [3:0] ad, input logic [15:0] d);
        @(posedge clk);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [3:0] ad, output logic [15:0] d);
        @(posedge clk);
        addr <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask

    task automatic next_irq(output int k);
        k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (irq0 !== 1'b1 && k < 70000);
    endtask

    task automatic edges(input int ch, input int w, input int x0, input int x1);
        a = e0;
        a1 = e1;
        src.pulse(ch, w);
        repeat (24) @(negedge clk);
        chk(16'(e0 - a), 16'(x0));
        chk(16'(e1 - a1), 16'(x1));
    endtask

    task automatic t_reset();
        logic [3:0] al [6];
        al = '{ITC_ADDR_CTL0, ITC_ADDR_CYCLE_BUFFER, ITC_ADDR_SECOND_BUFFER, ITC_ADDR_CNT, ITC_ADDR_OPT0, 4'hf};
        foreach (al[i]) begin
            rreg(al[i], v);
            chk(v, 16'h0000);
        end
        chkb(out0, 1'b0);
        chkb(out1, 1'b0);
    endtask

    task automatic t_interval();
        wreg(ITC_ADDR_CYCLE_BUFFER, 16'h0003);
        wreg(ITC_ADDR_SECOND_BUFFER, 16'h0001);
        wreg(ITC_ADDR_CTL0, 16'h0080);
        next_irq(n);
        t = out0;
        t1 = out1;
        a = s1;
        next_irq(n);
        chk(16'(n), 16'h0004);
        chk(16'(s1 - a), 16'h0001);
        chkb(out0, ~t);
        chkb(out1, ~t1);
        @(negedge clk);
        chkb(irq0, 1'b0);
        wreg(ITC_ADDR_CTL0, 16'h0081);
        next_irq(n);
        next_irq(n);
        chk(16'(n), 16'h0008);
        wreg(ITC_ADDR_CTL0, 16'h0000);
        rreg(ITC_ADDR_CNT, v);
        chk(v, 16'h0000);
        wreg(ITC_ADDR_SECOND_BUFFER, 16'h0005);
        wreg(ITC_ADDR_CTL0, 16'h0080);
        a = s1;
        t1 = out1;
        repeat (30) @(negedge clk);
        chk(16'(s1 - a), 16'h0000);
        chkb(out1, t1);
    endtask

    task automatic t_zero();
        wreg(ITC_ADDR_CTL0, 16'h0000);
        wreg(ITC_ADDR_CYCLE_BUFFER, 16'h0000);
        wreg(ITC_ADDR_CTL0, 16'h0080);
        next_irq(n);
        next_irq(n);
        chk(16'(n), 16'h0001);
        t = out0;
        @(negedge clk);
        chkb(out0, ~t);
        rreg(ITC_ADDR_CNT, v);
        chk(v, 16'h0000);
    endtask

    // A lowered cycle compare while counting is applied on purpose, so the wrap through the top shows.
    task automatic t_lowered();
        wreg(ITC_ADDR_CTL0, 16'h0000);
        wreg(ITC_ADDR_CYCLE_BUFFER, 16'h0040);
        t = out0;
        wreg(ITC_ADDR_CTL0, 16'h0080);
        repeat (6) @(negedge clk);
        chkb(out0, ~t);
        rreg(ITC_ADDR_CNT, v);
        chkb(v > 16'h0000 && v < 16'h0020, 1'b1);
        repeat (40) @(negedge clk);
        wreg(ITC_ADDR_CYCLE_BUFFER, 16'h0005);
        next_irq(n);
        chkb(n > 65400 && n < 65530, 1'b1);
        rreg(ITC_ADDR_OPT0, v);
        chk(v, 16'h0000);
        // The read above straddles part of a cycle, so the next full cycle is measured.
        next_irq(n);
        next_irq(n);
        chk(16'(n), 16'h0006);
    endtask

    task automatic t_batch();
        wreg(ITC_ADDR_CTL0, 16'h0000);
        wreg(ITC_ADDR_CTL1, 16'h0004);
        wreg(ITC_ADDR_CYCLE_BUFFER, 16'h0004);
        wreg(ITC_ADDR_CTL0, 16'h0080);
        wreg(ITC_ADDR_CYCLE_BUFFER, 16'h0006);
        wreg(ITC_ADDR_SECOND_BUFFER, 16'h0002);
        rreg(ITC_ADDR_STAT, v);
        chkb(v[2], 1'b1);
        repeat (20) @(negedge clk);
        rreg(ITC_ADDR_STAT, v);
        chkb(v[2], 1'b0);
        next_irq(n);
        next_irq(n);
        chk(16'(n), 16'h0007);
        wreg(ITC_ADDR_CTL0, 16'h0000);
        wreg(ITC_ADDR_CTL1, 16'h0000);
        wreg(ITC_ADDR_CTL0, 16'h0080);
        wreg(ITC_ADDR_SECOND_BUFFER, 16'h0002);
        rreg(ITC_ADDR_STAT, v);
        // A second-compare write arms in every mode; only batch modes act on the arm.
        chkb(v[2], 1'b1);
        wreg(ITC_ADDR_CYCLE_BUFFER, 16'h0008);
        next_irq(n);
        next_irq(n);
        chk(16'(n), 16'h0009);
    endtask

    task automatic t_filter();
        wreg(ITC_ADDR_CTL1, 16'h0002);
        wreg(ITC_ADDR_IOC1, 16'h000f);
        wreg(ITC_ADDR_NFC, 16'h0080);
        repeat (12) @(negedge clk);
        edges(0, 2, 0, 0);
        edges(0, 6, 2, 0);
        edges(1, 6, 0, 2);
        wreg(ITC_ADDR_NFC, 16'h0081);
        repeat (16) @(negedge clk);
        edges(0, 6, 0, 0);
        edges(0, 20, 2, 0);
        wreg(ITC_ADDR_NFC, 16'h0000);
        repeat (16) @(negedge clk);
        edges(0, 2, 2, 0);
        a = e0;
        wreg(ITC_ADDR_CTL1, 16'h0042);
        repeat (6) @(negedge clk);
        chk(16'(e0 - a), 16'h0001);
        wreg(ITC_ADDR_CTL1, 16'h0040);
        repeat (6) @(negedge clk);
        chk(16'(e0 - a), 16'h0001);
        edges(0, 6, 0, 0);
        wreg(ITC_ADDR_IOC1, 16'h0000);
        wreg(ITC_ADDR_CTL1, 16'h0001);
        edges(0, 6, 0, 0);
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_interval();
        t_zero();
        t_lowered();
        t_batch();
        t_filter();
        conclude();
    end

    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        conclude();
    end
endmodule
`default_nettype wire

// *** verif/itc_pin_src.sv ***
// Model of the external signal sources that drive the two capture inputs.
`timescale 1ns/1ps
`default_nettype none
module itc_pin_src (
    input wire logic CLK,
    output var logic PIN0,
    output var logic PIN1
);
    initial begin
        PIN0 = 1'b0;
        PIN1 = 1'b0;
    end

    // Pulses are held for whole clocks so that the filter sees an exact number of samples.
    task automatic pulse(input int ch, input int width);
        @(posedge CLK);
        if (ch == 0) begin
            PIN0 <= 1'b1;
        end else begin
            PIN1 <= 1'b1;
        end
        repeat (width) @(posedge CLK);
        if (ch == 0) begin
            PIN0 <= 1'b0;
        end else begin
            PIN1 <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire
